// [core/call_reset_pointer_add_ops.sv]
// What this block does
// - a word whose top five bits are 11011 is a relative call with an 11-bit signed word offset.
// - the relative call pushes its own address plus two onto the hardware stack before the pc moves, unless all 31 slots are full.
// - the call target is the call address plus two plus twice the signed offset.
// - the relative call is one word and two cycles, the second cycle doing nothing while fetch is redirected.
// - the word 0x00ff is the software reset, one word and one cycle, same effect as a master clear reset.
// - the software reset returns every register and flag, status included, to its reset value, except stack memory (kept) and fetchFlush (set).
// - 1110 1000 ffkk kkkk adds unsigned k to pointer f in one cycle without touching status flags.
// - add-and-return adds k to pointer two and loads the pc from the popped top of stack.
// - add-and-return takes two cycles, the second doing nothing.
// - the pointer-add form with select 11 is add-and-return on pointer two only.
`timescale 1ns/1ps
`default_nettype none
`include "crpa_map.svh"
module call_reset_pointer_add_ops
	import crpa_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [15:0] instrWord,
	input wire logic instrValid,
	input wire logic [4:0] statusIn,
	input wire logic statusWe,
	output logic [20:0] pcOut,
	output logic fetchFlush,
	output logic [11:0] pointer0,
	output logic [11:0] pointer1,
	output logic [11:0] pointer2,
	output logic [20:0] topOfStackValue,
	output logic [4:0] stackPtr,
	output logic [4:0] statusOut,
	output logic softResetPulse,
	output logic opDone
);
	typedef enum logic [1:0] {CRPA_EXEC, CRPA_NOP2} crpa_state_t;
	crpa_dec_if dif();
	crpa_decoder u_dec (.dif(dif));
	assign dif.opcode = instrWord;

	crpa_state_t state_ff;
	crpa_addr_t pc_ff;
	crpa_ptr_t ptr_ff [3];
	crpa_addr_t stack_ff [`CRPA_STACK_DEPTH];
	logic [4:0] sp_ff;
	logic [4:0] status_ff;
	logic swReset_ff;
	logic flush_ff;
	logic done_ff;

	function automatic crpa_ptr_t ptrAdd(input crpa_ptr_t p, input logic [5:0] k);
		ptrAdd = p + {6'h00, k};
	endfunction

	crpa_addr_t tos_ff;

	// decode is refused in the nop cycle and while a software reset is pending
	wire exec = instrValid && state_ff == CRPA_EXEC && !swReset_ff;
	wire doCall = exec && dif.op == CRPA_OP_CALL;
	wire doReset = exec && dif.op == CRPA_OP_RESET;
	wire doAdd = exec && dif.op == CRPA_OP_PTRADD && dif.ptrSel != `CRPA_RET_SEL;
	wire doAddRet = exec && dif.op == CRPA_OP_ADDRET;
	wire redirect = doCall || doAddRet;

	wire stackEmpty = sp_ff == 5'h00;
	wire stackFull = sp_ff == 5'(`CRPA_STACK_DEPTH);
	wire doPush = doCall && !stackFull;
	wire doPop = doAddRet && !stackEmpty;
	wire [4:0] spTop = sp_ff - 5'h01;
	wire [4:0] spBelow = sp_ff - 5'h02;

	wire crpa_addr_t retAddr = pc_ff + `CRPA_PC_STEP;
	wire crpa_addr_t callTarget = retAddr + dif.callOffset;
	// an empty stack reads as address zero, never an unwritten slot
	wire crpa_addr_t popAddr = stackEmpty ? `CRPA_PC_RESET : stack_ff[spTop];
	wire crpa_addr_t belowTop = (sp_ff < 5'h02) ? `CRPA_PC_RESET : stack_ff[spBelow];

	wire selPtr0 = doAdd && dif.ptrSel == 2'h0;
	wire selPtr1 = doAdd && dif.ptrSel == 2'h1;
	wire selPtr2 = (doAdd && dif.ptrSel == 2'h2) || doAddRet;

	wire crpa_state_t nxt_state = redirect ? CRPA_NOP2 : CRPA_EXEC;
	wire crpa_addr_t nxt_pc = doCall ? callTarget : doAddRet ? popAddr : (exec ? retAddr : pc_ff);
	wire [4:0] nxt_sp = doPush ? sp_ff + 5'h01 : doPop ? spTop : sp_ff;
	wire [4:0] nxt_status = statusWe ? statusIn : status_ff;
	wire nxt_flush = redirect || doReset;
	wire nxt_done = exec || state_ff == CRPA_NOP2;
	wire crpa_addr_t nxt_tos = doPush ? retAddr : doAddRet ? belowTop : popAddr;
	wire crpa_ptr_t nxt_ptr0 = selPtr0 ? ptrAdd(ptr_ff[0], dif.literal) : ptr_ff[0];
	wire crpa_ptr_t nxt_ptr1 = selPtr1 ? ptrAdd(ptr_ff[1], dif.literal) : ptr_ff[1];
	wire crpa_ptr_t nxt_ptr2 = selPtr2 ? ptrAdd(ptr_ff[2], dif.literal) : ptr_ff[2];

	// software reset acts as master clear on the following edge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			swReset_ff <= 1'b0;
		end else begin
			swReset_ff <= doReset;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= CRPA_EXEC;
		end else if (swReset_ff) begin
			state_ff <= CRPA_EXEC;
		end else begin
			state_ff <= nxt_state;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pc_ff <= `CRPA_PC_RESET;
		end else if (swReset_ff) begin
			pc_ff <= `CRPA_PC_RESET;
		end else begin
			pc_ff <= nxt_pc;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sp_ff <= 5'h00;
		end else if (swReset_ff) begin
			sp_ff <= 5'h00;
		end else begin
			sp_ff <= nxt_sp;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			status_ff <= `CRPA_STATUS_RESET;
		end else if (swReset_ff) begin
			status_ff <= `CRPA_STATUS_RESET;
		end else begin
			status_ff <= nxt_status;
		end
	end

	// flush also drops the word fetched during the reset pulse
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			flush_ff <= 1'b0;
		end else if (swReset_ff) begin
			flush_ff <= 1'b1;
		end else begin
			flush_ff <= nxt_flush;
		end
	end

	// done marks an executed or nop cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			done_ff <= 1'b0;
		end else if (swReset_ff) begin
			done_ff <= 1'b0;
		end else begin
			done_ff <= nxt_done;
		end
	end

	// top of stack view as it stands after this edge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tos_ff <= `CRPA_PC_RESET;
		end else if (swReset_ff) begin
			tos_ff <= `CRPA_PC_RESET;
		end else begin
			tos_ff <= nxt_tos;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ptr_ff[0] <= `CRPA_PTR_RESET;
		end else if (swReset_ff) begin
			ptr_ff[0] <= `CRPA_PTR_RESET;
		end else begin
			ptr_ff[0] <= nxt_ptr0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ptr_ff[1] <= `CRPA_PTR_RESET;
		end else if (swReset_ff) begin
			ptr_ff[1] <= `CRPA_PTR_RESET;
		end else begin
			ptr_ff[1] <= nxt_ptr1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ptr_ff[2] <= `CRPA_PTR_RESET;
		end else if (swReset_ff) begin
			ptr_ff[2] <= `CRPA_PTR_RESET;
		end else begin
			ptr_ff[2] <= nxt_ptr2;
		end
	end

	// stack memory holds no control state, so it is not reset
	always_ff @(posedge clk) begin
		if (doPush) begin
			stack_ff[sp_ff] <= retAddr;
		end
	end

	assign pcOut = pc_ff;
	assign fetchFlush = flush_ff;
	assign pointer0 = ptr_ff[0];
	assign pointer1 = ptr_ff[1];
	assign pointer2 = ptr_ff[2];
	assign topOfStackValue = tos_ff;
	assign stackPtr = sp_ff;
	assign statusOut = status_ff;
	assign softResetPulse = swReset_ff;
	assign opDone = done_ff;
endmodule // call_reset_pointer_add_ops
`default_nettype wire

// [core/crpa_dec_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface crpa_dec_if;
	logic [15:0] opcode;
	crpa_pkg::crpa_op_t op;
	logic [1:0] ptrSel;
	logic [5:0] literal;
	logic [20:0] callOffset;
	modport dec (input opcode, output op, ptrSel, literal, callOffset);
	modport core (output opcode, input op, ptrSel, literal, callOffset);
endinterface
`default_nettype wire

// [core/crpa_decoder.sv]
`timescale 1ns/1ps
`default_nettype none
`include "crpa_map.svh"
module crpa_decoder
	import crpa_pkg::*;
(
	crpa_dec_if.dec dif
);
	wire isCall = dif.opcode[15:11] == `CRPA_CALL_OP5;
	wire isReset = dif.opcode == `CRPA_SWRESET_OP;
	wire isPtrFam = dif.opcode[15:8] == `CRPA_PTRADD_OP8;
	wire isAddRet = isPtrFam && dif.opcode[7:6] == `CRPA_RET_SEL;
	assign dif.op = isCall ? CRPA_OP_CALL : isReset ? CRPA_OP_RESET : isAddRet ? CRPA_OP_ADDRET :
		isPtrFam ? CRPA_OP_PTRADD : CRPA_OP_OTHER;
	assign dif.ptrSel = isAddRet ? 2'h2 : dif.opcode[7:6];
	assign dif.literal = dif.opcode[5:0];
	// sign-extended word offset times two
	assign dif.callOffset = {{9{dif.opcode[10]}}, dif.opcode[10:0], 1'b0};
endmodule // crpa_decoder
`default_nettype wire

// [core/crpa_map.svh]
`ifndef CRPA_MAP_SVH
`define CRPA_MAP_SVH
`define CRPA_CALL_OP5 5'h1b
`define CRPA_SWRESET_OP 16'h00ff
`define CRPA_PTRADD_OP8 8'he8
`define CRPA_RET_SEL 2'h3
`define CRPA_PC_STEP 21'h000002
`define CRPA_PC_RESET 21'h000000
`define CRPA_PTR_RESET 12'h000
`define CRPA_STATUS_RESET 5'h00
`define CRPA_STACK_DEPTH 31
`endif

// [core/crpa_pkg.sv]
package crpa_pkg;
	typedef logic [20:0] crpa_addr_t;
	typedef logic [11:0] crpa_ptr_t;
	typedef enum logic [2:0] {CRPA_OP_OTHER, CRPA_OP_CALL, CRPA_OP_RESET, CRPA_OP_PTRADD, CRPA_OP_ADDRET} crpa_op_t;
endpackage

// [sim/call_reset_pointer_add_ops_test.sv]
`timescale 1ns/1ps
`default_nettype none
`define CK(a, e) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; $display("Error %0t %h %h", $time, a, e); end end
module call_reset_pointer_add_ops_test;
	logic clk = 0, resetn = 0, instrValid = 0, statusWe = 0, fetchFlush, softResetPulse, opDone;
	logic [15:0] instrWord = 0;
	logic [4:0] stackPtr, statusOut, sp = 0, st = 0;
	logic [20:0] pcOut, topOfStackValue, pc = 0, stk[32];
	logic [11:0] pointer0, pointer1, pointer2, p[3] = '{0, 0, 0};
	logic [87:0] q[$], nt;
	logic [31:0] r = 32'hee3a;
	int n_mismatch = 0, checks_done = 0, cyc = 0;
	call_reset_pointer_add_ops u_call_reset_pointer_add_ops(.clk, .resetn, .instrWord, .instrValid,
		.statusIn(r[4:0]), .statusWe, .pcOut, .fetchFlush, .pointer0, .pointer1, .pointer2, .topOfStackValue,
		.stackPtr, .statusOut, .softResetPulse, .opDone);
	initial forever #12.5 clk = ~clk;
	always @(posedge clk) if (++cyc == 1000) begin
		n_mismatch++;
		finish_test();
	end
	// results arrive after the nop cycle of two-cycle ops
	always @(negedge clk) if (opDone === 1'b1 && fetchFlush === 1'b0 && softResetPulse === 1'b0) begin
		nt = q.size() ? q.pop_front() : '1;
		`CK({pcOut, pointer0, pointer1, pointer2, stackPtr, topOfStackValue, statusOut}, nt)
	end
	function automatic logic [31:0] lfsr(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic ex(logic [15:0] w);
		bit c = w[15:11] == 5'h1b;
		bit a = w[15:6] == 10'h3a3;
		@(negedge clk);
		instrWord = w;
		instrValid = 1;
		if (c) begin
			if (sp != 5'h1f) stk[sp] = pc + 21'h2;
			if (sp != 5'h1f) sp++;
			pc = pc + 21'h2 + {{9{w[10]}}, w[10:0], 1'b0};
		end else if (a) begin
			p[2] += {6'h0, w[5:0]};
			sp--;
			pc = stk[sp];
		end else begin
			if (w[15:8] == 8'he8) p[w[7:6]] += {6'h0, w[5:0]};
			pc += 21'h2;
		end
		if (w != 16'h00ff) q.push_back({pc, p[0], p[1], p[2], sp, sp ? stk[sp - 5'h1] : 21'h0, st});
		// word offered in the nop cycle must be ignored
		if (c || a) @(negedge clk) instrWord = 16'he83f;
	endtask
	task automatic finish_test();
		if (n_mismatch == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		@(negedge clk) resetn = 1;
		ex(16'hdc00);
		ex(16'hdbff);
		for (int i = 0; i < 3; i++) ex({8'he8, 2'(i), 6'h3f});
		repeat (32) ex(16'hd800);
		while (sp) ex({10'h3a3, r[7:2]});
		repeat (80) begin
			r = lfsr(r);
			if (r[1:0] == 2'h1) ex({5'h1b, r[12:2]});
			else if (r[1] && sp) ex({10'h3a3, r[7:2]});
			else ex({8'he8, r[3:2] == 2'h3 ? 2'h2 : r[3:2], r[9:4]});
		end
		@(negedge clk) instrValid = 0;
		r[0] = 1'b1;
		st = r[4:0];
		statusWe = 1;
		@(negedge clk) statusWe = 0;
		ex(16'he805);
		ex(16'h00ff);
		@(negedge clk) instrValid = 0;
		repeat (2) @(negedge clk);
		`CK({pcOut, pointer0, pointer1, pointer2, stackPtr, topOfStackValue, statusOut, q.size() == 0}, 89'h1)
		finish_test();
	end
endmodule // call_reset_pointer_add_ops_test
bind call_reset_pointer_add_ops crpa_props u_crpa_props(.clk, .resetn, .instrWord, .instrValid, .pcOut,
	.fetchFlush, .softResetPulse, .stackPtr);
`default_nettype wire

// [sim/crpa_props.sv]
`timescale 1ns/1ps
`default_nettype none
module crpa_props(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [15:0] instrWord,
	input wire logic instrValid,
	input wire logic [20:0] pcOut,
	input wire logic fetchFlush,
	input wire logic softResetPulse,
	input wire logic [4:0] stackPtr
);
	wire tk = instrValid && !fetchFlush && !softResetPulse;
	wire cl = tk && instrWord[15:11] == 5'h1b;
	wire pa = tk && instrWord[15:8] == 8'he8;
	wire ar = pa && instrWord[7:6] == 2'h3;
	wire sr = tk && instrWord == 16'h00ff;
	wire [20:0] tg = pcOut + {{9{instrWord[10]}}, instrWord[10:0], 1'b0} + 21'h2;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_call_target: assert property (cl |=> pcOut == $past(tg)) else $error("target");
	a_call_push: assert property (cl && stackPtr < 5'h1f |=> stackPtr == $past(stackPtr) + 5'h1)
		else $error("push");
	a_redirect_nop: assert property (cl || ar |=> fetchFlush ##1 !fetchFlush && $stable(pcOut))
		else $error("nop");
	a_full_hold: assert property (cl && stackPtr == 5'h1f |=> stackPtr == 5'h1f) else $error("full");
	a_ret_pop: assert property (ar && stackPtr |=> stackPtr == $past(stackPtr) - 5'h1) else $error("pop");
	a_add_step: assert property (pa && !ar |=> pcOut == $past(pcOut) + 21'h2 && $stable(stackPtr))
		else $error("step");
	a_reset_pulse: assert property (sr |=> softResetPulse ##1 !softResetPulse) else $error("pulse");
	a_reset_state: assert property (sr |=> ##1 pcOut == 21'h0 && stackPtr == 5'h0) else $error("state");
	a_reset_flush: assert property (sr |=> fetchFlush ##1 fetchFlush) else $error("flush");
	c_call: cover property (cl);
	c_full: cover property (stackPtr == 5'h1f);
	c_ret: cover property (ar);
	c_reset: cover property (softResetPulse);
endmodule // crpa_props
`default_nettype wire
